// File: qdsu_map.svh
// Offsets, field positions, reset values and counts of the converter front end.
`ifndef QDSU_MAP_SVH
`define QDSU_MAP_SVH

`define QDSU_OFS_CTRL 6'h00
`define QDSU_OFS_STATUS 6'h04
`define QDSU_OFS_FRAMES 6'h08
`define QDSU_OFS_LAST 6'h0C
`define QDSU_BANK_IN 2'h1
`define QDSU_BANK_OUT 2'h2

`define QDSU_CTRL_DAISY 0
`define QDSU_CTRL_CCODE_LSB 1
`define QDSU_CTRL_RST 3'h0

`define QDSU_CC_ZERO 2'h0
`define QDSU_CC_MID 2'h1
`define QDSU_CC_FULL 2'h2

`define QDSU_FRAME_BITS 6'h20
`define QDSU_LAST_BIT 6'h1F
`define QDSU_FRM_ADDR_LSB 20
`define QDSU_FRM_DATA_LSB 4
`define QDSU_ADDR_ALL 4'hF

`define QDSU_INIT_WAIT 2'h2
`define QDSU_MCLK_NS 25
`define QDSU_SCLK_MAX_MHZ 50

`endif

// File: qdsu_pkg.sv
// Types shared by the converter front end modules.
package qdsu_pkg;

   typedef logic [15:0] qdsu_code_t;
   typedef logic [3:0][15:0] qdsu_bank_t;

   typedef struct packed {
      logic [5:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } qdsu_bus_req_t;

   typedef struct packed {
      logic [31:0] word;
      logic tgl;
   } qdsu_frame_t;

   typedef enum logic [1:0] {st_wait, st_run} qdsu_phase_t;

   typedef struct packed {
      logic [31:0] shift;
      logic [31:0] word;
      logic tgl;
      logic dz1;
      logic dz2;
   } qdsu_link_state_t;

   typedef struct packed {
      logic tg_s1;
      logic tg_s2;
      logic tg_s3;
      logic ld_s1;
      logic ld_s2;
      logic cl_s1;
      logic cl_s2;
      logic cl_s3;
      logic po_s1;
      logic po_s2;
      qdsu_phase_t phase;
      logic [1:0] wait_cnt;
      logic daisy;
      logic [1:0] ccode;
      qdsu_bank_t inreg;
      qdsu_bank_t outreg;
      logic [3:0] pend;
      logic [15:0] frames;
      logic [31:0] last;
      logic [31:0] rdata;
   } qdsu_top_state_t;

endpackage

// File: qdsu_link.sv
// Serial clock domain: frame shift register, frame hand-off and daisy output.
`timescale 1ns/100ps
`include "qdsu_map.svh"

module qdsu_link (
   // Link clock and reset
   input wire logic sclk,
   input wire logic rst_n,
   // Serial pins
   input wire logic frame_n,
   input wire logic serial_din,
   output logic serial_data_out,
   output logic rx_active,
   // System side
   input wire logic daisy_en,
   output qdsu_pkg::qdsu_frame_t frame
);
   import qdsu_pkg::*;

   qdsu_link_state_t st_r;
   qdsu_link_state_t st_nxt;
   logic [5:0] cnt_r;
   logic cnt_clr_n;
   logic sdo_r;

   // A high frame strobe clears the bit count at once, so an aborted frame
   // needs no further clock edge to be dropped.
   assign cnt_clr_n = rst_n & ~frame_n;

   always_ff @(negedge sclk or negedge cnt_clr_n) begin
      if (!cnt_clr_n) begin
         cnt_r <= 6'h00;
      end else if (cnt_r != `QDSU_FRAME_BITS) begin
         cnt_r <= cnt_r + 6'h01;
      end
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.dz1 = daisy_en;
      st_nxt.dz2 = st_r.dz1;
      if (!frame_n && cnt_r != `QDSU_FRAME_BITS) begin
         st_nxt.shift = {st_r.shift[30:0], serial_din};
         if (cnt_r == `QDSU_LAST_BIT) begin
            st_nxt.word = {st_r.shift[30:0], serial_din};
            st_nxt.tgl = ~st_r.tgl;
         end
      end
   end

   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         sdo_r <= 1'b0;
      end else begin
         sdo_r <= st_r.dz2 ? st_r.shift[31] : 1'b0;
      end
   end

   assign serial_data_out = sdo_r;
   assign rx_active = ~frame_n;
   assign frame.word = st_r.word;
   assign frame.tgl = st_r.tgl;

   chk_shift_sample: assert property (
      @(negedge sclk) disable iff (!rst_n)
      (!frame_n && cnt_r != `QDSU_FRAME_BITS) |=>
      st_r.shift[0] == $past(serial_din))
      else $error("shift register missed the data bit");
   chk_frame_done: assert property (
      @(negedge sclk) disable iff (!rst_n)
      (!frame_n && cnt_r == `QDSU_LAST_BIT) |=> st_r.tgl != $past(st_r.tgl))
      else $error("frame not handed off at the last edge");
   chk_abort_hold: assert property (
      @(negedge sclk) disable iff (!rst_n)
      (frame_n || cnt_r != `QDSU_LAST_BIT) |=> $stable(st_r.word))
      else $error("frame word changed without a full frame");
   chk_sdo_rise: assert property (
      @(posedge sclk) disable iff (!rst_n)
      1'b1 |=> serial_data_out ==
      ($past(st_r.dz2) ? $past(st_r.shift[31]) : 1'b0))
      else $error("serial out not updated on rising edge");
   cov_abort: cover property (@(negedge sclk) disable iff (!rst_n)
      (!frame_n && cnt_r == 6'h05) ##1 frame_n);
endmodule

// File: qdsu_top.sv
// Converter front end: serial frame intake, load and clear control, registers.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "qdsu_map.svh"

// Function
// - A low level on the load strobe copies every input register with new data into its output register at once.
// - A falling frame strobe enables the serial input buffers and the shift register.
// - After the frame strobe falls, 32 falling serial clock edges each take one bit to form a frame.
// - A frame strobe that rises before the 32nd edge drops the frame with no register change.
// - Serial data enters a 32-bit shift register on the falling serial clock edge.
// - In daisy-chain mode serial output data changes on the rising serial clock edge.
// - At power-up all four channels go to zero scale or midscale as the strap pin selects.
// - Clear acts on its falling edge and, while low, blocks every load strobe.
// - Clear loads input and output registers with the selected clear code, zero by default.
module qdsu_top (
   // System clock, enable and reset
   input wire logic mclk,
   input wire logic ce,
   input wire logic rst_n,
   // Serial link
   input wire logic sclk,
   input wire logic frame_n,
   input wire logic serial_din,
   output logic serial_data_out,
   output logic rx_active,
   // Converter control pins
   input wire logic load_outputs_n,
   input wire logic async_clear_n,
   input wire logic por_midscale,
   // Register port
   input qdsu_pkg::qdsu_bus_req_t bus_req,
   output logic [31:0] rdata,
   // Converter codes
   output qdsu_pkg::qdsu_bank_t dac_code
);
   import qdsu_pkg::*;

   localparam qdsu_code_t CODE_ZERO = 16'h0000;
   localparam qdsu_code_t CODE_MID = 16'h8000;
   localparam qdsu_code_t CODE_FULL = 16'hFFFF;

   qdsu_top_state_t st_r;
   qdsu_top_state_t st_nxt;
   qdsu_frame_t frame;
   logic frame_evt;
   logic clr_fall;
   logic clr_low;
   logic ld_act;
   logic run;
   logic [3:0] fr_addr;
   qdsu_code_t fr_data;
   qdsu_code_t ccode_val;
   logic [3:0] fr_hit;

   qdsu_link u_link (
      .sclk(sclk),
      .rst_n(rst_n),
      .frame_n(frame_n),
      .serial_din(serial_din),
      .serial_data_out(serial_data_out),
      .rx_active(rx_active),
      .daisy_en(st_r.daisy),
      .frame(frame)
   );

   assign run = (st_r.phase == st_run);
   // The frame word is stable for the many cycles that a new frame needs,
   // so it is read directly once the toggle edge has been synchronised.
   assign frame_evt = st_r.tg_s2 ^ st_r.tg_s3;
   assign clr_fall = st_r.cl_s3 & ~st_r.cl_s2;
   assign clr_low = ~st_r.cl_s2;
   assign ld_act = ~st_r.ld_s2;
   assign fr_addr = frame.word[`QDSU_FRM_ADDR_LSB +: 4];
   assign fr_data = frame.word[`QDSU_FRM_DATA_LSB +: 16];

   always_comb begin
      unique case (st_r.ccode)
         `QDSU_CC_MID: ccode_val = CODE_MID;
         `QDSU_CC_FULL: ccode_val = CODE_FULL;
         default: ccode_val = CODE_ZERO;
      endcase
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         fr_hit[i] = (fr_addr == `QDSU_ADDR_ALL) || (fr_addr == 4'(i));
      end
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = 32'h0000_0000;
      // Every pin and the frame toggle pass two flops first.
      st_nxt.tg_s1 = frame.tgl;
      st_nxt.tg_s2 = st_r.tg_s1;
      st_nxt.tg_s3 = st_r.tg_s2;
      st_nxt.ld_s1 = load_outputs_n;
      st_nxt.ld_s2 = st_r.ld_s1;
      st_nxt.cl_s1 = async_clear_n;
      st_nxt.cl_s2 = st_r.cl_s1;
      st_nxt.cl_s3 = st_r.cl_s2;
      st_nxt.po_s1 = por_midscale;
      st_nxt.po_s2 = st_r.po_s1;

      unique case (st_r.phase)
         st_wait: begin
            if (st_r.wait_cnt == `QDSU_INIT_WAIT) begin
               for (int i = 0; i < 4; i++) begin
                  st_nxt.inreg[i] = st_r.po_s2 ? CODE_MID : CODE_ZERO;
                  st_nxt.outreg[i] = st_r.po_s2 ? CODE_MID : CODE_ZERO;
               end
               st_nxt.phase = st_run;
            end else begin
               st_nxt.wait_cnt = st_r.wait_cnt + 2'h1;
            end
         end
         st_run: begin
            // Load first, then a new frame, so a frame in the same cycle
            // keeps its pending flag.
            if (ld_act && !clr_low) begin
               for (int i = 0; i < 4; i++) begin
                  if (st_r.pend[i]) begin
                     st_nxt.outreg[i] = st_r.inreg[i];
                  end
               end
               st_nxt.pend = 4'h0;
            end
            if (frame_evt) begin
               st_nxt.last = frame.word;
               st_nxt.frames = st_r.frames + 16'h0001;
               for (int i = 0; i < 4; i++) begin
                  if (fr_hit[i]) begin
                     st_nxt.inreg[i] = fr_data;
                     st_nxt.pend[i] = 1'b1;
                  end
               end
            end
            if (clr_fall) begin
               for (int i = 0; i < 4; i++) begin
                  st_nxt.inreg[i] = ccode_val;
                  st_nxt.outreg[i] = ccode_val;
               end
               st_nxt.pend = 4'h0;
            end
         end
      endcase

      if (bus_req.wr && bus_req.addr == `QDSU_OFS_CTRL) begin
         st_nxt.daisy = bus_req.wdata[`QDSU_CTRL_DAISY];
         st_nxt.ccode = bus_req.wdata[`QDSU_CTRL_CCODE_LSB +: 2];
      end

      if (bus_req.rd && bus_req.addr[1:0] == 2'h0) begin
         if (bus_req.addr == `QDSU_OFS_CTRL) begin
            st_nxt.rdata = {29'h0, st_r.ccode, st_r.daisy};
         end else if (bus_req.addr == `QDSU_OFS_STATUS) begin
            st_nxt.rdata = {26'h0, run, clr_low, st_r.pend};
         end else if (bus_req.addr == `QDSU_OFS_FRAMES) begin
            st_nxt.rdata = {16'h0, st_r.frames};
         end else if (bus_req.addr == `QDSU_OFS_LAST) begin
            st_nxt.rdata = st_r.last;
         end else if (bus_req.addr[5:4] == `QDSU_BANK_IN) begin
            st_nxt.rdata = {16'h0, st_r.inreg[bus_req.addr[3:2]]};
         end else if (bus_req.addr[5:4] == `QDSU_BANK_OUT) begin
            st_nxt.rdata = {16'h0, st_r.outreg[bus_req.addr[3:2]]};
         end
      end
   end

   // Synchronisers reset to the idle pin level so reset release is no edge.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.tg_s1 <= 1'b0;
         st_r.ld_s1 <= 1'b1;
         st_r.ld_s2 <= 1'b1;
         st_r.cl_s1 <= 1'b1;
         st_r.cl_s2 <= 1'b1;
         st_r.cl_s3 <= 1'b1;
         st_r.phase <= st_wait;
         {st_r.ccode, st_r.daisy} <= `QDSU_CTRL_RST;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign rdata = st_r.rdata;
   assign dac_code = st_r.outreg;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   chk_load_copies: assert property (
      ce && run && ld_act && !clr_low && st_r.pend[0] |=>
      st_r.outreg[0] == $past(st_r.inreg[0]))
      else $error("load did not copy channel 0");
   chk_out_hold: assert property (
      ce && run && !ld_act && !clr_fall |=> $stable(st_r.outreg))
      else $error("output changed with no load or clear");
   chk_frame_write: assert property (
      ce && run && frame_evt && !clr_fall && fr_hit[2] |=>
      st_r.inreg[2] == $past(fr_data) && st_r.pend[2])
      else $error("completed frame not written to channel 2");
   chk_in_stable: assert property (
      ce && run && !frame_evt && !clr_fall |=> $stable(st_r.inreg))
      else $error("input register changed without a frame");
   chk_por_level: assert property (
      ce && st_r.phase == st_wait && st_r.wait_cnt == `QDSU_INIT_WAIT |=>
      st_r.outreg == {4{($past(st_r.po_s2) ? CODE_MID : CODE_ZERO)}})
      else $error("power-up level not taken from strap");
   chk_clear_code: assert property (
      ce && run && clr_fall |=> st_r.outreg == {4{$past(ccode_val)}} &&
      st_r.inreg == {4{$past(ccode_val)}})
      else $error("clear did not load the clear code");
   chk_clear_blocks: assert property (
      ce && run && clr_low && !clr_fall |=> $stable(st_r.outreg))
      else $error("load acted while clear held low");
   chk_clear_wins: assert property (
      ce && run && clr_fall && ld_act && !frame_evt |=>
      st_r.pend == 4'h0 ##0 st_r.outreg == {4{$past(ccode_val)}})
      else $error("load beat a simultaneous clear");
   chk_sync_depth: assert property (
      ce ##1 ce |=> ld_act == !$past(st_r.ld_s1))
      else $error("load strobe skipped a synchroniser stage");
   chk_read_ctrl: assert property (
      ce && bus_req.rd && bus_req.addr == `QDSU_OFS_CTRL |=>
      rdata == {29'h0, $past(st_r.ccode), $past(st_r.daisy)} ##1 !ce ||
      rdata == 32'h0 || $past(bus_req.rd))
      else $error("control read data wrong");

   cov_frame: cover property (ce && run && frame_evt);
   cov_load: cover property (ce && run && ld_act && st_r.pend != 4'h0);
   cov_clear: cover property (ce && run && clr_fall);
   cov_daisy_frame: cover property (ce && run && frame_evt && st_r.daisy);
endmodule

// File: qdsu_host.sv
// Host controller model that drives the three-wire serial write pins.
`timescale 1ns/100ps
module qdsu_host (
   // Serial pins
   output logic sclk,
   output logic frame_n,
   output logic serial_din,
   // Daisy input from the device
   input wire logic serial_data_out
);
   // The clock is kept at 50 MHz, the fastest rate the device accepts.
   localparam int HALF_NS = 10;

   initial begin
      sclk = 1'b1;
      frame_n = 1'b1;
      serial_din = 1'b0;
   end

   // Sends the top nbits of word MSB first and returns what the daisy
   // output showed at the same falling edges; the clock idles high.
   task automatic send(input logic [31:0] word, input int nbits,
                       output logic [31:0] echo);
      echo = '0;
      frame_n = 1'b0;
      #(2 * HALF_NS);
      for (int i = 0; i < nbits; i++) begin
         serial_din = word[31 - i];
         #(HALF_NS);
         sclk = 1'b0;
         echo = {echo[30:0], serial_data_out};
         #(HALF_NS);
         sclk = 1'b1;
      end
      #(HALF_NS / 2);
      frame_n = 1'b1;
      serial_din = ~serial_din;
   endtask
endmodule

// File: qdsu_top_tb.sv
// Self-checking bench of the converter front end.
`timescale 1ns/100ps
module qdsu_top_tb;
   import qdsu_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic load_outputs_n = 1'b1;
   logic async_clear_n = 1'b1;
   logic por_midscale = 1'b0;
   qdsu_bus_req_t bus_req = '0;
   logic sclk, frame_n, serial_din, serial_data_out, rx_active;
   logic [31:0] rdata;
   logic [31:0] echo;
   qdsu_bank_t dac_code;
   int miscompares = 0;
   int tests_run = 0;

   always #12.5 mclk = ~mclk;

   qdsu_top qdsu_top_i (
      .mclk(mclk), .ce(1'b1), .rst_n(rst_n), .sclk(sclk),
      .frame_n(frame_n), .serial_din(serial_din),
      .serial_data_out(serial_data_out), .rx_active(rx_active),
      .load_outputs_n(load_outputs_n), .async_clear_n(async_clear_n),
      .por_midscale(por_midscale), .bus_req(bus_req), .rdata(rdata),
      .dac_code(dac_code)
   );

   qdsu_host qdsu_host_i (
      .sclk(sclk), .frame_n(frame_n), .serial_din(serial_din),
      .serial_data_out(serial_data_out)
   );

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %08X, seen %08X", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] exp,
                     input string what);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      #1 chk(what, exp, rdata);
   endtask

   task automatic frame(input logic [3:0] ch, input logic [15:0] code,
                        input int n);
      qdsu_host_i.send({8'h00, ch, code, 4'h0}, n, echo);
      cyc(8);
   endtask

   task automatic pulse_load;
      @(posedge mclk);
      load_outputs_n <= 1'b0;
      cyc(4);
      load_outputs_n <= 1'b1;
      cyc(4);
   endtask

   task automatic t_power;
      logic [31:0] e;
      for (int m = 1; m >= 0; m--) begin
         e = m ? 32'h8000 : 32'h0;
         @(posedge mclk);
         por_midscale <= m[0];
         rst_n <= 1'b0;
         cyc(2);
         rst_n <= 1'b1;
         cyc(5);
         for (int c = 0; c < 4; c++) begin
            chk("power-up code", e, 32'(dac_code[c]));
            rd(6'h10 + 6'(4 * c), e, "power-up input");
         end
      end
      $display("power-up test done");
   endtask

   task automatic t_load;
      frame(4'h1, 16'h1234, 32);
      chk("daisy off", 32'h0, echo);
      frame(4'h2, 16'hBEEF, 32);
      chk("held output", 32'h0, 32'(dac_code[1]));
      rd(6'h14, 32'h1234, "input ch1");
      rd(6'h04, 32'h26, "pending");
      rd(6'h08, 32'h2, "frames");
      rd(6'h0C, 32'h002BEEF0, "last word");
      pulse_load;
      chk("load ch1", 32'h1234, 32'(dac_code[1]));
      chk("load ch2", 32'hBEEF, 32'(dac_code[2]));
      rd(6'h04, 32'h20, "pending done");
      rd(6'h3C, 32'h0, "unmapped");
      $display("load test done");
   endtask

   task automatic t_abort;
      fork
         frame(4'h0, 16'hAAAA, 31);
         #5 chk("buffers on", 32'h1, 32'(rx_active));
      join
      chk("buffers off", 32'h0, 32'(rx_active));
      rd(6'h10, 32'h0, "aborted input");
      rd(6'h08, 32'h2, "aborted count");
      $display("abort test done");
   endtask

   task automatic t_tied;
      @(posedge mclk);
      load_outputs_n <= 1'b0;
      frame(4'h3, 16'h5A5A, 32);
      chk("follow ch3", 32'h5A5A, 32'(dac_code[3]));
      frame(4'hF, 16'h0F0F, 32);
      for (int c = 0; c < 4; c++)
         chk("follow all", 32'h0F0F, 32'(dac_code[c]));
      load_outputs_n <= 1'b1;
      $display("tied load test done");
   endtask

   task automatic t_clear;
      logic [31:0] e;
      for (int k = 0; k < 4; k++) begin
         e = (k == 1) ? 32'h8000 : (k == 2) ? 32'hFFFF : 32'h0;
         wr(6'h00, 32'(k) << 1);
         frame(4'h0, 16'h1357, 32);
         @(posedge mclk);
         async_clear_n <= 1'b0;
         load_outputs_n <= 1'b0;
         cyc(6);
         chk("clear output", e, 32'(dac_code[0]));
         rd(6'h10, e, "clear input");
         frame(4'h1, 16'h2468, 32);
         chk("load blocked", e, 32'(dac_code[1]));
         rd(6'h04, 32'h32, "clear status");
         load_outputs_n <= 1'b1;
         @(posedge mclk);
         async_clear_n <= 1'b1;
         pulse_load;
         chk("load after", 32'h2468, 32'(dac_code[1]));
         chk("clear kept", e, 32'(dac_code[0]));
      end
      $display("clear test done");
   endtask

   task automatic t_daisy;
      wr(6'h00, 32'h1);
      frame(4'h0, 16'hC3C3, 32);
      frame(4'h1, 16'h7E81, 32);
      chk("daisy out", 32'h000C3C30, echo);
      pulse_load;
      chk("daisy load", 32'h7E81, 32'(dac_code[1]));
      $display("daisy test done");
   endtask

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      t_power;
      t_load;
      t_abort;
      t_tied;
      t_clear;
      t_daisy;
      end_of_test;
   end

   // Cuts a hung run short and counts it as a mismatch.
   initial begin
      #1000000;
      miscompares++;
      end_of_test;
   end
endmodule
